// ### src/spm_device.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spm_device
    import spm_pkg::*;
#(
    parameter int          OP_CYCLES_P = OP_CYCLES,
    parameter logic [15:0] BOOT_START  = 16'h7000
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clockEnable,
    spm_if.device            cpu,
    input  wire logic        bootVectorFuse,
    input  wire logic [7:0]  fuseLowByte,
    input  wire logic [7:0]  fuseHighByte,
    input  wire logic [2:0]  fuseExtendedByte,
    input  wire logic [5:0]  lockBits,
    input  wire logic        eepromWriteActive,
    input  wire logic [15:0] flashReadWord,
    input  wire logic [5:0]  bufReadIndex,
    output logic [15:0]      bufReadWord,
    output logic [14:0]      flashReadAddr,
    output logic             nvmBusy,
    output nvm_op_type       nvmOpKind,
    output logic [8:0]       nvmPage,
    output logic [5:0]       nvmLockMask,
    output logic             readSectionBlocked,
    output logic [15:0]      resetVector
);
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_ARMED   = 3'b010,
        ST_OPERATE = 3'b100
    } dev_fsm_type;

    typedef struct packed {
        dev_fsm_type                  state;
        logic                         irqEn;
        logic                         sectionBusy;
        logic                         lockSet;
        logic                         pgWrite;
        logic                         pgErase;
        logic                         enable;
        logic [4:0]                   cmdHigh;
        logic [2:0]                   window;
        nvm_op_type                   opKind;
        logic [8:0]                   opPage;
        logic [5:0]                   lockMask;
        logic [PAGE_WORDS-1:0][15:0]  buffer;
        logic [PAGE_WORDS-1:0]        bufValid;
        logic                         readPending;
        logic                         readLsb;
        logic                         readBlocked;
        logic [14:0]                  readAddr;
        logic [7:0]                   loadData;
        logic                         loadValid;
        logic [15:0]                  bufWord;
        logic                         halt;
        logic                         blocked;
        logic                         irq;
        logic                         busy;
        logic                         vectorTaken;
        logic [15:0]                  vector;
    } dev_state_type;

    dev_state_type s_reg;
    dev_state_type s_next;
    logic          opDone;
    logic [5:0]    cmdCode;

    spm_op_timer #(.CYCLES(OP_CYCLES_P)) opTimer (
        .clock       (clock),
        .srst        (srst),
        .clockEnable (clockEnable),
        .start       (s_next.state == ST_OPERATE && s_reg.state != ST_OPERATE),
        .done        (opDone)
    );

    assign cmdCode = {s_reg.cmdHigh, s_reg.enable};

    always_comb begin
        s_next = s_reg;
        s_next.loadValid = 1'b0;
        // Boot vector chosen from the fuse in the first cycle after reset
        if (!s_reg.vectorTaken) begin
            s_next.vectorTaken = 1'b1;
            s_next.vector = bootVectorFuse ? APP_RESET_VECTOR : BOOT_START;
        end
        // Completion of a pending ordinary flash byte read
        if (s_reg.readPending) begin
            s_next.readPending = 1'b0;
            s_next.loadValid = 1'b1;
            if (s_reg.readBlocked) begin
                s_next.loadData = BLOCKED_BYTE;
            end else begin
                s_next.loadData = s_reg.readLsb ? flashReadWord[15:8] : flashReadWord[7:0];
            end
        end
        case (s_reg.state)
            ST_IDLE: begin
                // Writes during an EEPROM write cannot arm a sequence
                if (cpu.ctrlWrite) begin
                    s_next.irqEn = cpu.ctrlValue[CTRL_IRQ_EN];
                    if (cpu.ctrlValue[CTRL_ENABLE] && !eepromWriteActive) begin
                        s_next.enable = 1'b1;
                        s_next.lockSet = cpu.ctrlValue[CTRL_LOCKSET];
                        s_next.pgWrite = cpu.ctrlValue[CTRL_PGWRITE];
                        s_next.pgErase = cpu.ctrlValue[CTRL_PGERASE];
                        s_next.cmdHigh = cpu.ctrlValue[5:1];
                        s_next.window = '0;
                        s_next.state = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                s_next.window = s_reg.window + 1'b1;
                if (cpu.storeReq && !eepromWriteActive) begin
                    s_next.state = ST_IDLE;
                    s_next.enable = 1'b0;
                    s_next.lockSet = 1'b0;
                    s_next.pgWrite = 1'b0;
                    s_next.pgErase = 1'b0;
                    case (cmdCode)
                        CMD_BUF_LOAD: begin
                            // Second load of one slot simply overwrites it
                            s_next.buffer[wordOf(cpu.pointer)] = cpu.wordData;
                            s_next.bufValid[wordOf(cpu.pointer)] = 1'b1;
                        end
                        CMD_ERASE, CMD_WRITE: begin
                            s_next.opPage = pageOf(cpu.pointer);
                            s_next.opKind = (cmdCode == CMD_ERASE) ? NVM_ERASE : NVM_WRITE;
                            s_next.halt = pageOf(cpu.pointer) >= BLOCKING_SECTION_FIRST_PAGE;
                            s_next.blocked = 1'b1;
                            s_next.sectionBusy = 1'b1;
                            s_next.enable = 1'b1;
                            s_next.pgWrite = s_reg.pgWrite;
                            s_next.pgErase = s_reg.pgErase;
                            s_next.state = ST_OPERATE;
                        end
                        CMD_LOCK: begin
                            // Pointer ignored; no section is blocked
                            s_next.lockMask = ~cpu.wordData[5:0];
                            s_next.opKind = NVM_LOCK;
                            s_next.enable = 1'b1;
                            s_next.lockSet = 1'b1;
                            s_next.state = ST_OPERATE;
                        end
                        CMD_REENABLE: begin
                            s_next.sectionBusy = 1'b0;
                            s_next.bufValid = '0;
                        end
                        default: begin
                        end
                    endcase
                end else if (cpu.loadReq && s_reg.lockSet && s_reg.window < LOAD_WINDOW
                             && !eepromWriteActive) begin
                    s_next.loadValid = 1'b1;
                    case (cpu.pointer)
                        RB_FUSE_LOW:  s_next.loadData = fuseLowByte;
                        RB_LOCK:      s_next.loadData = {2'h3, lockBits};
                        RB_FUSE_EXT:  s_next.loadData = {5'h1f, fuseExtendedByte};
                        RB_FUSE_HIGH: s_next.loadData = fuseHighByte;
                        default:      s_next.loadData = BLOCKED_BYTE;
                    endcase
                    s_next.enable = 1'b0;
                    s_next.lockSet = 1'b0;
                    s_next.state = ST_IDLE;
                end else if (s_reg.window == STORE_WINDOW - 1'b1) begin
                    // Window expired: the whole sequence is dropped
                    s_next.enable = 1'b0;
                    s_next.lockSet = 1'b0;
                    s_next.pgWrite = 1'b0;
                    s_next.pgErase = 1'b0;
                    s_next.state = ST_IDLE;
                end
            end
            ST_OPERATE: begin
                if (cpu.ctrlWrite) begin
                    s_next.irqEn = cpu.ctrlValue[CTRL_IRQ_EN];
                end
                if (opDone) begin
                    s_next.enable = 1'b0;
                    s_next.lockSet = 1'b0;
                    s_next.pgWrite = 1'b0;
                    s_next.pgErase = 1'b0;
                    s_next.halt = 1'b0;
                    s_next.blocked = 1'b0;
                    s_next.opKind = NVM_IDLE;
                    if (s_reg.opKind == NVM_WRITE) begin
                        s_next.bufValid = '0;
                    end
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
        // Ordinary load outside a readback sequence
        if (cpu.loadReq && !(s_reg.state == ST_ARMED && s_reg.lockSet)) begin
            s_next.readPending = 1'b1;
            s_next.readLsb = cpu.pointer[0];
            s_next.readAddr = cpu.pointer[15:1];
            s_next.readBlocked = s_reg.blocked && pageOf(cpu.pointer) < BLOCKING_SECTION_FIRST_PAGE;
        end
        // EEPROM write throws away a partly or fully loaded buffer
        if (eepromWriteActive && |s_reg.bufValid) begin
            s_next.bufValid = '0;
        end
        s_next.bufWord = s_reg.bufValid[bufReadIndex] ? s_reg.buffer[bufReadIndex] : ERASED_WORD;
        s_next.irq = s_next.irqEn && !s_next.enable;
        // Own flop so the busy output carries no decode glitch
        s_next.busy = (s_next.state == ST_OPERATE);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.vector <= APP_RESET_VECTOR;
            s_reg.bufWord <= ERASED_WORD;
        end else if (clockEnable) begin
            s_reg <= s_next;
        end
    end

    assign cpu.ctrlStatus = {s_reg.irqEn, s_reg.sectionBusy, 1'b0, 1'b0,
                             s_reg.lockSet, s_reg.pgWrite, s_reg.pgErase, s_reg.enable};
    assign cpu.loadData = s_reg.loadData;
    assign cpu.loadValid = s_reg.loadValid;
    assign cpu.cpuHalt = s_reg.halt;
    assign cpu.spmIrq = s_reg.irq;
    assign bufReadWord = s_reg.bufWord;
    assign flashReadAddr = s_reg.readAddr;
    assign nvmBusy = s_reg.busy;
    assign nvmOpKind = s_reg.opKind;
    assign nvmPage = s_reg.opPage;
    assign nvmLockMask = s_reg.lockMask;
    assign readSectionBlocked = s_reg.blocked;
    assign resetVector = s_reg.vector;
endmodule
`default_nettype wire

// ### src/spm_host.sv
`timescale 1ns/1ps
`default_nettype none
module spm_host
    import spm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clockEnable,
    spm_if.host              dev,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b001,
        H_INSTR = 3'b010,
        H_WAIT  = 3'b100
    } host_fsm_type;

    typedef struct packed {
        host_fsm_type state;
        logic [15:0]  pointer;
        logic [15:0]  wordData;
        logic [9:0]   seq;
        logic         ctrlWrite;
        logic         storeReq;
        logic         loadReq;
        logic [7:0]   loadData;
        logic         loadDone;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
    } host_state_type;

    host_state_type s_reg;
    host_state_type s_next;
    logic           access;

    assign access = psel && penable && !s_reg.pready;

    always_comb begin
        s_next = s_reg;
        s_next.ctrlWrite = 1'b0;
        s_next.storeReq = 1'b0;
        s_next.loadReq = 1'b0;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        case (s_reg.state)
            H_IDLE: begin
            end
            H_INSTR: begin
                // Instruction follows the control write by one cycle
                s_next.storeReq = s_reg.seq[SEQ_STORE];
                s_next.loadReq = s_reg.seq[SEQ_LOAD];
                s_next.state = s_reg.seq[SEQ_LOAD] ? H_WAIT : H_IDLE;
            end
            H_WAIT: begin
                if (dev.loadValid) begin
                    s_next.loadData = dev.loadData;
                    s_next.loadDone = 1'b1;
                    s_next.state = H_IDLE;
                end
            end
            default: begin
                s_next.state = H_IDLE;
            end
        endcase
        if (access) begin
            s_next.pready = 1'b1;
            case (paddr)
                REG_POINTER: begin
                    s_next.prdata = {16'h0000, s_reg.pointer};
                    if (pwrite) begin
                        s_next.pointer = pwdata[15:0];
                    end
                end
                REG_DATA: begin
                    s_next.prdata = {16'h0000, s_reg.wordData};
                    if (pwrite) begin
                        s_next.wordData = pwdata[15:0];
                    end
                end
                REG_SEQUENCE: begin
                    s_next.prdata = {22'h000000, s_reg.seq};
                    // Stalls until the previous sequence is over and the core runs
                    if (pwrite) begin
                        if (s_reg.state == H_IDLE && !dev.cpuHalt) begin
                            s_next.seq = pwdata[9:0];
                            s_next.ctrlWrite = 1'b1;
                            s_next.loadDone = 1'b0;
                            s_next.state = (pwdata[SEQ_STORE] || pwdata[SEQ_LOAD]) ? H_INSTR : H_IDLE;
                        end else begin
                            s_next.pready = 1'b0;
                        end
                    end
                end
                REG_STATUS: begin
                    s_next.prdata = {13'h0000, dev.cpuHalt, dev.spmIrq, s_reg.loadDone,
                                     s_reg.loadData, dev.ctrlStatus};
                    s_next.pslverr = pwrite;
                end
                default: begin
                    s_next.prdata = '0;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.state <= H_IDLE;
        end else if (clockEnable) begin
            s_reg <= s_next;
        end
    end

    assign dev.ctrlWrite = s_reg.ctrlWrite;
    assign dev.ctrlValue = s_reg.seq[7:0];
    assign dev.storeReq = s_reg.storeReq;
    assign dev.loadReq = s_reg.loadReq;
    assign dev.pointer = s_reg.pointer;
    assign dev.wordData = s_reg.wordData;
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
endmodule
`default_nettype wire

// ### src/spm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spm_if;
    logic        ctrlWrite;
    logic [7:0]  ctrlValue;
    logic        storeReq;
    logic        loadReq;
    logic [15:0] pointer;
    logic [15:0] wordData;
    logic [7:0]  ctrlStatus;
    logic [7:0]  loadData;
    logic        loadValid;
    logic        cpuHalt;
    logic        spmIrq;

    modport device (input ctrlWrite, ctrlValue, storeReq, loadReq, pointer, wordData,
                    output ctrlStatus, loadData, loadValid, cpuHalt, spmIrq);
    modport host (output ctrlWrite, ctrlValue, storeReq, loadReq, pointer, wordData,
                  input ctrlStatus, loadData, loadValid, cpuHalt, spmIrq);
endinterface
`default_nettype wire

// ### src/spm_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module spm_op_timer
    import spm_pkg::*;
#(
    parameter int CYCLES = OP_CYCLES
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic clockEnable,
    input  wire logic start,
    output logic      done
);
    typedef struct packed {
        logic                run;
        logic [OP_CNT_W-1:0] count;
        logic                done;
    } timer_state_type;

    timer_state_type s_reg;
    timer_state_type s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            s_next.run = 1'b1;
            s_next.count = OP_CNT_W'(CYCLES - 1);
        end else if (s_reg.run) begin
            if (s_reg.count == '0) begin
                s_next.run = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.count = s_reg.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
        end else if (clockEnable) begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
endmodule
`default_nettype wire

// ### src/spm_pkg.sv
package spm_pkg;
    // Operation time, ns as specified, cycles derived (least time rounds up)
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int OP_TIME_MIN_NS  = 3_700_000;
    localparam int OP_TIME_MAX_NS  = 4_500_000;
    localparam int OP_CYCLES       = (OP_TIME_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OP_CNT_W        = 18;
    // Instruction windows after the control write, in cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW  = 3'h3;
    // Control register bit positions
    localparam int CTRL_IRQ_EN  = 7;
    localparam int CTRL_BUSY    = 6;
    localparam int CTRL_REEN    = 4;
    localparam int CTRL_LOCKSET = 3;
    localparam int CTRL_PGWRITE = 2;
    localparam int CTRL_PGERASE = 1;
    localparam int CTRL_ENABLE  = 0;
    // Command codes on control bits 5..0
    localparam logic [5:0] CMD_BUF_LOAD = 6'h01;
    localparam logic [5:0] CMD_ERASE    = 6'h03;
    localparam logic [5:0] CMD_WRITE    = 6'h05;
    localparam logic [5:0] CMD_LOCK     = 6'h09;
    localparam logic [5:0] CMD_REENABLE = 6'h11;
    // Pointer layout: byte address, word in page, page number
    localparam int WORD_LSB = 1;
    localparam int WORD_MSB = 6;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_MSB = 15;
    localparam int PAGE_WORDS = 64;
    localparam logic [8:0]  BLOCKING_SECTION_FIRST_PAGE  = 9'h1c0;
    localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] RB_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] RB_LOCK      = 16'h0001;
    localparam logic [15:0] RB_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] RB_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] ERASED_WORD  = 16'hffff;
    localparam logic [7:0]  BLOCKED_BYTE = 8'hff;
    // Host register map (byte addresses)
    localparam logic [7:0] REG_POINTER  = 8'h00;
    localparam logic [7:0] REG_DATA     = 8'h04;
    localparam logic [7:0] REG_SEQUENCE = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam int SEQ_STORE = 8;
    localparam int SEQ_LOAD  = 9;

    typedef enum logic [1:0] {NVM_IDLE = 2'h0, NVM_ERASE = 2'h1, NVM_WRITE = 2'h2, NVM_LOCK = 2'h3} nvm_op_type;

    function automatic logic [8:0] pageOf(input logic [15:0] ptr);
        return ptr[PAGE_MSB:PAGE_LSB];
    endfunction

    function automatic logic [5:0] wordOf(input logic [15:0] ptr);
        return ptr[WORD_MSB:WORD_LSB];
    endfunction
endpackage

// ### tb/spm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spm_assertions
    import spm_pkg::*;
#(
    parameter int OP_CYCLES_P = 20
) (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        storeReq,
    input wire logic        loadReq,
    input wire logic [15:0] pointer,
    input wire logic [7:0]  ctrlStatus,
    input wire logic [7:0]  loadData,
    input wire logic        loadValid,
    input wire logic        cpuHalt,
    input wire logic        spmIrq
);
    // Margin below the timer count, since the exact start edge is the designer's
    localparam int OP_LO = OP_CYCLES_P - 2;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence opStart;
        storeReq && ctrlStatus[0] && (ctrlStatus[1] || ctrlStatus[2] || ctrlStatus[3]);
    endsequence
    sequence opRun;
        ctrlStatus[0] throughout (##OP_LO 1);
    endsequence
    a_irq_level: assert property (spmIrq == (ctrlStatus[7] && !ctrlStatus[0]))
        else $error("irq level wrong");
    a_readback_lock: assert property (loadReq && ctrlStatus[3] && ctrlStatus[0] && pointer == RB_LOCK
        |=> loadValid && loadData[7:6] == 2'b11 && !ctrlStatus[0] && !ctrlStatus[3])
        else $error("lock readback wrong");
    a_window_expiry: assert property ($rose(ctrlStatus[0]) ##0 (!storeReq && !loadReq)[*6] |-> !ctrlStatus[0])
        else $error("enable not cleared after window");
    a_busy_set: assert property (opStart ##0 !ctrlStatus[3] |=> ctrlStatus[6] && ctrlStatus[0])
        else $error("busy not set");
    a_busy_clear: assert property ($fell(ctrlStatus[6]) |-> $past(storeReq) || $past(storeReq, 2))
        else $error("busy cleared without reenable");
    a_lock_noblock: assert property (opStart ##0 ctrlStatus[3] |=> !ctrlStatus[6] && !cpuHalt)
        else $error("lock blocked flash");
    a_halt_blocking: assert property (opStart ##0 ctrlStatus[1] && pointer[15:7] >= BLOCKING_SECTION_FIRST_PAGE |=> cpuHalt)
        else $error("no halt");
    a_op_length: assert property (opStart |=> opRun ##[1:6] !ctrlStatus[0])
        else $error("operation length wrong");
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import spm_pkg::*;
;
    localparam logic [7:0] FLOW  = 8'ha5;
    localparam logic [7:0] FHIGH = 8'h3c;
    localparam logic [2:0] FEXT  = 3'h5;
    localparam logic [5:0] LOCKS = 6'h2b;
    logic        clock = 0, srst = 1, run = 1, boot = 1, ee = 0;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr, busy, blocked;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [5:0]  idx = 6'h00, lockMask;
    logic [15:0] bufWord, resetVector;
    logic [14:0] fAddr;
    logic [8:0]  page;
    nvm_op_type  opKind;
    int          err_count = 0, cmp_count = 0;
    logic [15:0] rowPtr [6] = '{RB_FUSE_LOW, RB_LOCK, RB_FUSE_EXT, RB_FUSE_HIGH, 16'h0123, 16'h0122};
    logic [31:0] rowSeq [6] = '{32'h209, 32'h209, 32'h209, 32'h209, 32'h200, 32'h200};
    logic [7:0]  rowExp [6] = '{FLOW, {2'b11, LOCKS}, {5'h1f, FEXT}, FHIGH, 8'h5a, 8'hcb};
    // Flash content is a fixed function of the word address
    wire logic [15:0] fWord = {1'b0, fAddr} ^ 16'h5a5a;
    spm_if link ();
    spm_host spm_host_i (.clock(clock), .srst(srst), .clockEnable(run), .dev(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    spm_device #(.OP_CYCLES_P(20)) spm_device_i (.clock(clock), .srst(srst), .clockEnable(run), .cpu(link),
        .bootVectorFuse(boot), .fuseLowByte(FLOW), .fuseHighByte(FHIGH), .fuseExtendedByte(FEXT), .lockBits(LOCKS),
        .eepromWriteActive(ee), .flashReadWord(fWord), .bufReadIndex(idx), .bufReadWord(bufWord),
        .flashReadAddr(fAddr), .nvmBusy(busy), .nvmOpKind(opKind), .nvmPage(page), .nvmLockMask(lockMask),
        .readSectionBlocked(blocked), .resetVector(resetVector));
    spm_assertions #(.OP_CYCLES_P(20)) spm_assertions_i (.clock(clock), .srst(srst), .storeReq(link.storeReq),
        .loadReq(link.loadReq), .pointer(link.pointer), .ctrlStatus(link.ctrlStatus), .loadData(link.loadData),
        .loadValid(link.loadValid), .cpuHalt(link.cpuHalt), .spmIrq(link.spmIrq));
    always #12.5 clock = ~clock;
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // One idle cycle before each setup keeps every strobe to one assignment per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // Stalls are unbounded here; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic waitIdle();
        do apb(0, REG_STATUS, 0); while (rdata[0] !== 1'b0);
    endtask
    task automatic waitLoad();
        do apb(0, REG_STATUS, 0); while (rdata[16] !== 1'b1);
    endtask
    task automatic doReset();
        srst <= 1;
        repeat (12) @(posedge clock);
        srst <= 0;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        finish_test();
    end
    initial begin
        doReset();
        chk("resetVector", APP_RESET_VECTOR, resetVector);
        chk("bufWord", ERASED_WORD, bufWord);
        for (int i = 0; i < 6; i++) begin
            apb(1, REG_POINTER, rowPtr[i]);
            apb(1, REG_SEQUENCE, rowSeq[i]);
            waitLoad();
            chk("loadByte", {1'b1, rowExp[i]}, rdata[16:8]);
        end
        apb(1, REG_DATA, 32'h1234);
        apb(1, REG_POINTER, 32'h02fe);
        apb(1, REG_SEQUENCE, 32'h101);
        idx <= 6'h3f;
        repeat (3) @(posedge clock);
        chk("bufWord", 32'h1234, bufWord);
        apb(1, REG_POINTER, 32'h0280);
        apb(1, REG_SEQUENCE, 32'h103);
        apb(1, REG_POINTER, 32'hffff);
        chk("page", 32'h5, page);
        chk("opKind", NVM_ERASE, opKind);
        chk("blocked", 32'h1, blocked);
        apb(1, REG_POINTER, 32'h0122);
        apb(1, REG_SEQUENCE, 32'h200);
        waitLoad();
        chk("blockedRead", {1'b1, BLOCKED_BYTE}, rdata[16:8]);
        waitIdle();
        chk("busyHeld", 32'h1, rdata[6]);
        chk("bufKept", 32'h1234, bufWord);
        apb(1, REG_POINTER, 32'h0280);
        apb(1, REG_SEQUENCE, 32'h105);
        repeat (2) @(posedge clock);
        chk("opKind", NVM_WRITE, opKind);
        waitIdle();
        chk("bufCleared", ERASED_WORD, bufWord);
        apb(1, REG_SEQUENCE, 32'h111);
        apb(0, REG_STATUS, 0);
        chk("busyCleared", 32'h0, rdata[6]);
        apb(1, REG_POINTER, 32'he000);
        apb(1, REG_SEQUENCE, 32'h103);
        repeat (3) @(posedge clock);
        chk("cpuHalt", 32'h1, link.cpuHalt);
        waitIdle();
        apb(1, REG_SEQUENCE, 32'h111);
        apb(1, REG_DATA, 32'h00f0);
        apb(1, REG_SEQUENCE, 32'h109);
        repeat (3) @(posedge clock);
        chk("lockMask", 32'h0f, lockMask);
        chk("opKind", NVM_LOCK, opKind);
        chk("lockBlocked", 32'h0, blocked);
        waitIdle();
        apb(1, REG_SEQUENCE, 32'h009);
        apb(0, REG_STATUS, 0);
        chk("armed", 32'h9, rdata[3:0]);
        apb(0, REG_STATUS, 0);
        chk("expired", 32'h0, rdata[3:0]);
        apb(1, REG_POINTER, 32'h0000);
        apb(1, REG_SEQUENCE, 32'h101);
        idx <= 6'h00;
        repeat (3) @(posedge clock);
        chk("slotZero", 32'h00f0, bufWord);
        ee <= 1;
        repeat (3) @(posedge clock);
        chk("eeBuf", ERASED_WORD, bufWord);
        apb(1, REG_SEQUENCE, 32'h103);
        apb(0, REG_STATUS, 0);
        chk("eeEnable", 32'h0, rdata[0]);
        chk("eeBusy", 32'h0, busy);
        ee <= 0;
        apb(0, 8'h40, 0);
        chk("slverr", 32'h1, rerr);
        chk("unmapped", 32'h0, rdata);
        apb(1, REG_STATUS, 0);
        chk("roWrite", 32'h1, rerr);
        apb(1, REG_SEQUENCE, 32'h080);
        apb(0, REG_STATUS, 0);
        chk("irq", 32'h1, rdata[17]);
        boot <= 0;
        doReset();
        chk("bootVector", 32'h7000, resetVector);
        finish_test();
    end
endmodule
`default_nettype wire
